// ==== pkg/pmp_cfg_pkg.sv ====
package pmp_cfg_pkg;
  // Register word indices on the plain register port
  localparam logic [3:0]  IDX_MODE  = 4'h0;    // Port mode and link options
  localparam logic [3:0]  IDX_CTL2  = 4'h1;    // port_control_status_two
  localparam logic [3:0]  IDX_CTL3  = 4'h2;    // port_control_three
  localparam logic [3:0]  IDX_CTL4  = 4'h3;    // port_control_four
  localparam logic [3:0]  IDX_CS1CF = 4'h4;    // select_one_config
  localparam logic [3:0]  IDX_CS1BS = 4'h5;    // select_one_base
  localparam logic [3:0]  IDX_CS2CF = 4'h6;    // select_two_config
  localparam logic [3:0]  IDX_CS2BS = 4'h7;    // select_two_base
  // Mode register fields
  localparam int          MODE_LSB    = 0;     // Two-bit port mode
  localparam int          MODE_MUX    = 2;     // Latch phase enable
  localparam int          MODE_CSPIN  = 3;     // Selects on address pins 15/14
  localparam int          MODE_ACKW   = 4;     // Wait for acknowledge
  localparam logic [1:0]  PMODE_MASTER = 2'h3; // Master operation code
  // Control two fields
  localparam int          C2_BUSY = 15;        // Busy flag
  localparam int          C2_ERR  = 13;        // Transaction error flag
  localparam int          C2_TOUT = 12;        // Time-out flag
  localparam int          C2_AREQ = 11;        // Alternate request status
  localparam int          C2_CUR  = 10;        // Current master flag
  localparam int          C2_MSEL = 8;         // Master select LSB
  localparam logic [1:0]  MSEL_CPU    = 2'h0;  // CPU owns the port
  localparam logic [1:0]  MSEL_ALT    = 2'h1;  // Alternate master owns it
  localparam logic [1:0]  MSEL_RSVD   = 2'h2;  // Reserved code
  localparam logic [1:0]  MSEL_BYPASS = 2'h3;  // Alternate direct pin access
  // Control three fields
  localparam int          C3_WREN = 15;        // Write/enable strobe pin
  localparam int          C3_RDEN = 14;        // Read strobe pin
  localparam int          C3_BE1  = 13;        // High lane enable pin
  localparam int          C3_BE0  = 12;        // Low lane enable pin
  localparam int          C3_AWM  = 9;         // Latch strobe wait LSB
  localparam int          C3_AWE  = 8;         // Latch hold wait
  // Select configuration fields
  localparam int          CF_DIS  = 15;        // Select disable
  localparam int          CF_POL  = 14;        // Select polarity
  localparam int          CF_PEN  = 13;        // Select pin enable
  localparam int          CF_BEP  = 12;        // Lane enable polarity
  localparam int          CF_WRITE_STROBE_POLARITY = 10;        // Write/enable strobe polarity
  localparam int          CF_READ_STROBE_POLARITY = 9;         // Read or direction polarity
  localparam int          CF_SM   = 8;         // Strobe style
  localparam int          CF_ACK_POLARITY = 7;         // Acknowledge polarity
  localparam int          CF_SZ   = 5;         // Bus width LSB
  localparam logic [1:0]  SZ_8    = 2'h0;      // 8-bit bus
  localparam logic [1:0]  SZ_4    = 2'h1;      // 4-bit bus
  localparam logic [1:0]  SZ_16   = 2'h2;      // 16-bit bus
  localparam logic [1:0]  SZ_RSVD = 2'h3;      // Reserved width
  // Writable masks and reset values
  localparam logic [15:0] MASK_MODE = 16'h001F; // Mode bits kept
  localparam logic [15:0] MASK_C3   = 16'hF77F; // Control three bits kept
  localparam logic [15:0] MASK_CF   = 16'hF7E0; // Config bits kept
  localparam logic [15:0] MASK_BS   = 16'hFF88; // Base bits kept
  localparam logic [15:0] RST_CS1BS = 16'h0200; // Select one base at reset
  localparam logic [15:0] RST_CS2BS = 16'h0600; // Select two base at reset
  localparam logic [23:0] ADDR_TOP  = 24'hFFFFFF; // Top of address space
  // Timing: one clock is a quarter instruction cycle
  localparam int          CLK_NS      = 25;    // Clock period
  localparam int          TCY_NS      = 100;   // Instruction cycle
  localparam int          QTR_PER_TCY = TCY_NS / CLK_NS; // Clocks per cycle
  localparam int          HALF_QTR    = QTR_PER_TCY / 2; // Half cycle
  localparam int          STROBE_TCY  = 1;     // Strobe without ack wait
  localparam int          STROBE_CYC  = STROBE_TCY * QTR_PER_TCY;
  localparam int          TOUT_TCY    = 255;   // Acknowledge time-out
  localparam int          TOUT_CYC    = TOUT_TCY * QTR_PER_TCY;

  // One bus request from either master
  typedef struct packed {
    logic [23:0] addr;   // Byte address
    logic [15:0] wdata;  // Write data
    logic        write;  // 1 write, 0 read
  } req_t;
endpackage : pmp_cfg_pkg

// ==== src/parallel_master_bus_config.sv ====
// Operation
// - Busy flag set during transaction, cleared after
// - Sticky error flag on illegal transaction
// - Sticky time-out flag on transaction time-out
// - Status bit mirrors alternate master request
// - Current master flag, one for CPU
// - Master select: CPU, alternate, reserved, bypass
// - Reserved space top; zero means full space
// - Enables for strobe and lane pins
// - Latch strobe lasts half plus whole cycles
// - Address hold quarter or five quarters
// - Per-pin enable for address pins
// - Pins 15/14 address or select, else I/O
// - Pin 0 address or latch strobe
// - Per select disable bit
// - Per select polarity and pin enable
// - Per select lane enable polarity
// - Strobe style separate or combined
// - Strobe polarities follow strobe style
// - Acknowledge polarity per select
// - Bus width 8, 4, 16 or reserved
// - Base registers keep bits 23:15 and 11
// - Zero select two base extends select one
// - Port mode field, master at 11
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module parallel_master_bus_config (
  input  wire logic                 clk_i,       // 40 MHz clock
  input  wire logic                 rstn_i,      // Async reset, active low
  input  wire logic [3:0]           reg_addr_i,  // Register index
  input  wire logic [15:0]          reg_wdata_i, // Register write data
  input  wire logic                 reg_wr_i,    // Write strobe
  input  wire logic                 reg_rd_i,    // Read strobe
  output logic      [15:0]          reg_rdata_o, // Read data, next cycle
  input  wire logic                 cpu_valid_i, // CPU request
  input  wire pmp_cfg_pkg::req_t    cpu_req_i,   // CPU request body
  input  wire logic                 alt_valid_i, // Alternate master request
  input  wire pmp_cfg_pkg::req_t    alt_req_i,   // Alternate request body
  output logic                      req_ready_o, // Request taken when idle
  output logic                      done_o,      // Transaction end pulse
  output logic      [15:0]          rdata_o,     // Read data of transaction
  input  wire logic                 ack_input_i, // External acknowledge
  output logic      [22:0]          addr_pins_o,  // Address pin levels
  output logic      [22:0]          addr_pins_oe_o, // Address pin enables
  output logic      [15:0]          data_pins_o,  // Data pin levels
  output logic      [15:0]          data_pins_oe_o, // Data pin enables
  input  wire logic [15:0]          data_pins_i,  // Data pin inputs
  output logic      [1:0]           select_pin_o,  // Select pin levels
  output logic      [1:0]           select_pin_oe_o, // Select pin enables
  output logic                      write_strobe_pin_o, // Write or enable
  output logic                      write_strobe_pin_oe_o, // Its enable
  output logic                      read_strobe_pin_o,  // Read or direction
  output logic                      read_strobe_pin_oe_o, // Its enable
  output logic                      high_lane_enable_pin_o, // High lane
  output logic                      high_lane_enable_pin_oe_o, // Its enable
  output logic                      low_lane_enable_pin_o, // Low lane
  output logic                      low_lane_enable_pin_oe_o  // Its enable
);
  // Transaction phases
  typedef enum logic [2:0] {
    ST_IDLE, ST_LATCH, ST_HOLD, ST_STROBE, ST_END
  } state_t;

  logic [1:0]  rst_sync;      // Reset release chain
  logic        rstn;          // Synchronised reset
  logic [15:0] mode_reg;      // Mode register
  logic [1:0]  master_select; // Master select field
  logic [7:0]  reserved_addr_high; // Reserved space bits 23:16
  logic        err_flag;      // Sticky error
  logic        tout_flag;     // Sticky time-out
  logic        alt_master_request; // Request status
  logic        current_master_flag; // 1 CPU owns the port
  logic [15:0] ctl3;          // port_control_three
  logic [15:0] ctl4;          // port_control_four
  logic [15:0] cs1cf;         // select_one_config
  logic [15:0] cs2cf;         // select_two_config
  logic [15:0] cs1bs;         // select_one_base
  logic [15:0] cs2bs;         // select_two_base
  state_t      state;         // Phase register
  logic [10:0] cnt;           // Phase countdown
  logic        sel2;          // Active select is two
  pmp_cfg_pkg::req_t cur;     // Latched request
  logic [15:0] ctl2_rd;       // Control two read view

  // Reset released through two flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) rst_sync <= 2'h0;
    else         rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rstn = rst_sync[1];

  // Register port decode
  wire wr_mode = reg_wr_i && reg_addr_i == pmp_cfg_pkg::IDX_MODE;
  wire wr_c2   = reg_wr_i && reg_addr_i == pmp_cfg_pkg::IDX_CTL2;
  wire wr_c3   = reg_wr_i && reg_addr_i == pmp_cfg_pkg::IDX_CTL3;
  wire wr_c4   = reg_wr_i && reg_addr_i == pmp_cfg_pkg::IDX_CTL4;
  wire wr_1cf  = reg_wr_i && reg_addr_i == pmp_cfg_pkg::IDX_CS1CF;
  wire wr_1bs  = reg_wr_i && reg_addr_i == pmp_cfg_pkg::IDX_CS1BS;
  wire wr_2cf  = reg_wr_i && reg_addr_i == pmp_cfg_pkg::IDX_CS2CF;
  wire wr_2bs  = reg_wr_i && reg_addr_i == pmp_cfg_pkg::IDX_CS2BS;

  // Mode and control field views
  wire [1:0] port_mode = mode_reg[pmp_cfg_pkg::MODE_LSB +: 2];
  wire       master_on = port_mode == pmp_cfg_pkg::PMODE_MASTER;
  wire       addr_mux  = mode_reg[pmp_cfg_pkg::MODE_MUX];
  wire       cs_on_pin = mode_reg[pmp_cfg_pkg::MODE_CSPIN];
  wire       ack_wait  = mode_reg[pmp_cfg_pkg::MODE_ACKW];
  wire [1:0] latch_strobe_wait = ctl3[pmp_cfg_pkg::C3_AWM +: 2];
  wire       latch_hold_wait   = ctl3[pmp_cfg_pkg::C3_AWE];
  wire [22:0] addr_pin_en = {ctl3[6:0], ctl4};

  // Writable register storage
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= 16'h0000;
      master_select <= 2'h0;
      reserved_addr_high <= 8'h00;
      ctl3 <= 16'h0000;
      ctl4 <= 16'h0000;
      cs1cf <= 16'h0000;
      cs2cf <= 16'h0000;
      cs1bs <= pmp_cfg_pkg::RST_CS1BS;
      cs2bs <= pmp_cfg_pkg::RST_CS2BS;
    end else begin
      if (wr_mode) mode_reg <= reg_wdata_i & pmp_cfg_pkg::MASK_MODE;
      if (wr_c2) begin
        master_select <= reg_wdata_i[pmp_cfg_pkg::C2_MSEL +: 2];
        reserved_addr_high <= reg_wdata_i[7:0];
      end
      if (wr_c3) ctl3 <= reg_wdata_i & pmp_cfg_pkg::MASK_C3;
      if (wr_c4) ctl4 <= reg_wdata_i;
      if (wr_1cf) cs1cf <= reg_wdata_i & pmp_cfg_pkg::MASK_CF;
      if (wr_2cf) cs2cf <= reg_wdata_i & pmp_cfg_pkg::MASK_CF;
      if (wr_1bs) cs1bs <= reg_wdata_i & pmp_cfg_pkg::MASK_BS;
      if (wr_2bs) cs2bs <= reg_wdata_i & pmp_cfg_pkg::MASK_BS;
    end
  end

  // Base address decode; bits 23:15 and 11 only
  wire [23:0] base1 = {cs1bs[15:7], 3'h0, cs1bs[3], 11'h000};
  wire [23:0] base2 = {cs2bs[15:7], 3'h0, cs2bs[3], 11'h000};
  wire        cs2_zero = cs2bs == 16'h0000;
  wire [23:0] last2 = (reserved_addr_high == 8'h00) ?
                      pmp_cfg_pkg::ADDR_TOP :
                      {reserved_addr_high, 16'h0000} - 24'h000001;

  // Requesting master and its range decode
  wire        use_alt  = master_select == pmp_cfg_pkg::MSEL_ALT;
  wire        src_ok   = master_select == pmp_cfg_pkg::MSEL_CPU ||
                         use_alt;
  wire        src_vld  = use_alt ? alt_valid_i : cpu_valid_i;
  wire pmp_cfg_pkg::req_t src = use_alt ? alt_req_i : cpu_req_i;
  wire        hit1 = src.addr >= base1 &&
                     (cs2_zero || src.addr < base2) &&
                     !cs1cf[pmp_cfg_pkg::CF_DIS];
  wire        hit2 = !cs2_zero && src.addr >= base2 &&
                     src.addr <= last2 &&
                     !cs2cf[pmp_cfg_pkg::CF_DIS];
  wire [15:0] hit_cf = hit2 ? cs2cf : cs1cf;
  wire        size_bad = hit_cf[pmp_cfg_pkg::CF_SZ +: 2] ==
                         pmp_cfg_pkg::SZ_RSVD;
  wire        take = state == ST_IDLE && src_ok && src_vld;
  wire        legal = master_on && (hit1 || hit2) && !size_bad;
  wire        start_ok  = take && legal;
  wire        start_bad = take && !legal;

  // Settings of the select in use
  wire [15:0] cf = sel2 ? cs2cf : cs1cf;
  wire [1:0]  width = cf[pmp_cfg_pkg::CF_SZ +: 2];
  wire        ack_hit = ack_input_i == cf[pmp_cfg_pkg::CF_ACK_POLARITY];
  wire [10:0] latch_len = 11'(pmp_cfg_pkg::HALF_QTR - 1 +
                          pmp_cfg_pkg::QTR_PER_TCY * latch_strobe_wait);
  wire [10:0] hold_len  = 11'(pmp_cfg_pkg::QTR_PER_TCY *
                          latch_hold_wait);
  wire        cnt_zero  = cnt == 11'h000;
  wire        tout_hit  = ack_wait && cnt_zero && !ack_hit;

  // Transaction phase sequencer
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt <= 11'h000;
      sel2 <= 1'b0;
      cur <= '0;
    end else begin
      case (state)
        ST_IDLE: if (start_ok) begin
          cur <= src;
          sel2 <= hit2;
          state <= addr_mux ? ST_LATCH : ST_STROBE;
          cnt <= addr_mux ? latch_len :
                 ack_wait ? 11'(pmp_cfg_pkg::TOUT_CYC - 1) :
                            11'(pmp_cfg_pkg::STROBE_CYC - 1);
        end
        // Latch strobe of half plus whole cycles
        ST_LATCH: if (cnt_zero) begin
          state <= ST_HOLD;
          cnt <= hold_len;
        end else cnt <= cnt - 11'h001;
        // Address hold of one or five quarters
        ST_HOLD: if (cnt_zero) begin
          state <= ST_STROBE;
          cnt <= ack_wait ? 11'(pmp_cfg_pkg::TOUT_CYC - 1) :
                            11'(pmp_cfg_pkg::STROBE_CYC - 1);
        end else cnt <= cnt - 11'h001;
        // Strobe until count or acknowledge
        ST_STROBE: if (cnt_zero || (ack_wait && ack_hit)) begin
          state <= ST_END;
        end else cnt <= cnt - 11'h001;
        ST_END:  state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Status flags; a set wins over a software clear
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      err_flag <= 1'b0;
      tout_flag <= 1'b0;
      alt_master_request <= 1'b0;
      current_master_flag <= 1'b1;
    end else begin
      if (start_bad) err_flag <= 1'b1;
      else if (wr_c2 && !reg_wdata_i[pmp_cfg_pkg::C2_ERR]) err_flag <= 1'b0;
      if (state == ST_STROBE && tout_hit) tout_flag <= 1'b1;
      else if (wr_c2 && !reg_wdata_i[pmp_cfg_pkg::C2_TOUT])
        tout_flag <= 1'b0;
      alt_master_request <= alt_valid_i;
      if (state == ST_IDLE)
        current_master_flag <= master_select == pmp_cfg_pkg::MSEL_CPU;
    end
  end

  // Bus lane mask from width
  wire [15:0] wmask = (width == pmp_cfg_pkg::SZ_16) ? 16'hFFFF :
                      (width == pmp_cfg_pkg::SZ_4)  ? 16'h000F :
                                                      16'h00FF;

  // Transaction result and data pins
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      done_o <= start_bad || state == ST_END;
      if (state == ST_STROBE && !cur.write)
        rdata_o <= data_pins_i & wmask;
    end
  end

  wire busy = master_on && state != ST_IDLE;
  wire in_tx  = state == ST_STROBE;
  wire bypass = master_select == pmp_cfg_pkg::MSEL_BYPASS;
  wire act_tx = state != ST_IDLE;

  // Strobe levels by style and polarity
  wire sm = cf[pmp_cfg_pkg::CF_SM];
  wire wr_act = sm ? in_tx : in_tx && cur.write;
  wire rd_act = sm ? !cur.write : in_tx && !cur.write;
  wire wr_lvl = wr_act ~^ cf[pmp_cfg_pkg::CF_WRITE_STROBE_POLARITY];
  wire rd_lvl = rd_act ~^ cf[pmp_cfg_pkg::CF_READ_STROBE_POLARITY];
  wire be_hi  = act_tx && width == pmp_cfg_pkg::SZ_16;
  wire [1:0] cs_act = {act_tx && sel2, act_tx && !sel2};
  wire [1:0] cs_lvl = {cs_act[1] ~^ cs2cf[pmp_cfg_pkg::CF_POL],
                       cs_act[0] ~^ cs1cf[pmp_cfg_pkg::CF_POL]};
  wire [22:0] a_out = bypass ? alt_req_i.addr[22:0] : cur.addr[22:0];
  wire latch_on = addr_mux && state == ST_LATCH;

  // Pin outputs
  assign addr_pins_o = {a_out[22:16],
                        cs_on_pin ? cs_lvl[1] : a_out[15],
                        cs_on_pin ? cs_lvl[0] : a_out[14],
                        a_out[13:1],
                        addr_mux ? latch_on : a_out[0]};
  assign addr_pins_oe_o = addr_pin_en;
  assign data_pins_o    = cur.wdata & wmask;
  assign data_pins_oe_o = (act_tx && cur.write) ? wmask : 16'h0000;
  assign select_pin_o   = cs_lvl;
  assign select_pin_oe_o = {cs2cf[pmp_cfg_pkg::CF_PEN] &&
                            !cs2cf[pmp_cfg_pkg::CF_DIS],
                            cs1cf[pmp_cfg_pkg::CF_PEN] &&
                            !cs1cf[pmp_cfg_pkg::CF_DIS]};
  assign write_strobe_pin_o = wr_lvl;
  assign write_strobe_pin_oe_o = ctl3[pmp_cfg_pkg::C3_WREN];
  assign read_strobe_pin_o = rd_lvl;
  assign read_strobe_pin_oe_o = ctl3[pmp_cfg_pkg::C3_RDEN];
  assign high_lane_enable_pin_o = be_hi ~^ cf[pmp_cfg_pkg::CF_BEP];
  assign high_lane_enable_pin_oe_o = ctl3[pmp_cfg_pkg::C3_BE1];
  assign low_lane_enable_pin_o = act_tx ~^ cf[pmp_cfg_pkg::CF_BEP];
  assign low_lane_enable_pin_oe_o = ctl3[pmp_cfg_pkg::C3_BE0];
  assign req_ready_o = state == ST_IDLE && src_ok;

  // Read view of control two
  assign ctl2_rd = {busy, 1'b0, err_flag, tout_flag, alt_master_request,
                    current_master_flag, master_select, reserved_addr_high};

  // Register read data, one cycle later
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) reg_rdata_o <= 16'h0000;
    else if (reg_rd_i) begin
      case (reg_addr_i)
        pmp_cfg_pkg::IDX_MODE:  reg_rdata_o <= mode_reg;
        pmp_cfg_pkg::IDX_CTL2:  reg_rdata_o <= ctl2_rd;
        pmp_cfg_pkg::IDX_CTL3:  reg_rdata_o <= ctl3;
        pmp_cfg_pkg::IDX_CTL4:  reg_rdata_o <= ctl4;
        pmp_cfg_pkg::IDX_CS1CF: reg_rdata_o <= cs1cf;
        pmp_cfg_pkg::IDX_CS1BS: reg_rdata_o <= cs1bs;
        pmp_cfg_pkg::IDX_CS2CF: reg_rdata_o <= cs2cf;
        pmp_cfg_pkg::IDX_CS2BS: reg_rdata_o <= cs2bs;
        default:                reg_rdata_o <= 16'h0000; // Unmapped
      endcase
    end
  end

  // Checks
  property p_busy;
    @(posedge clk_i) disable iff (!rstn)
    start_ok |=> busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set");

  property p_busy_clr;
    @(posedge clk_i) disable iff (!rstn)
    state == ST_END |=> !busy;
  endproperty
  a_busy_clr: assert property (p_busy_clr)
    else $error("busy not cleared");

  property p_err;
    @(posedge clk_i) disable iff (!rstn)
    start_bad |=> err_flag && done_o;
  endproperty
  a_err: assert property (p_err) else $error("error not flagged");

  property p_tout;
    @(posedge clk_i) disable iff (!rstn)
    state == ST_STROBE && tout_hit |=> tout_flag ##1 done_o;
  endproperty
  a_tout: assert property (p_tout) else $error("timeout lost");

  property p_areq;
    @(posedge clk_i) disable iff (!rstn)
    ##1 alt_master_request == $past(alt_valid_i);
  endproperty
  a_areq: assert property (p_areq) else $error("request status");

  property p_latch;
    @(posedge clk_i) disable iff (!rstn)
    $rose(state == ST_LATCH) && latch_strobe_wait == 2'h0 |->
    (state == ST_LATCH) [*2] ##1 state == ST_HOLD;
  endproperty
  a_latch: assert property (p_latch) else $error("latch length");

  property p_hold;
    @(posedge clk_i) disable iff (!rstn)
    $rose(state == ST_HOLD) && latch_hold_wait |->
    (state == ST_HOLD) [*5] ##1 state == ST_STROBE;
  endproperty
  a_hold: assert property (p_hold) else $error("hold length");

  property p_cs2z;
    @(posedge clk_i) disable iff (!rstn)
    cs2_zero |-> !hit2;
  endproperty
  a_cs2z: assert property (p_cs2z) else $error("select two hit");

  property p_mode;
    @(posedge clk_i) disable iff (!rstn)
    take && !master_on |=> state == ST_IDLE && err_flag;
  endproperty
  a_mode: assert property (p_mode) else $error("non-master start");
endmodule : parallel_master_bus_config

// ==== verification/ext_mem_model.sv ====
`timescale 1ns/100ps
module ext_mem_model (
  input  wire logic        clk_i,     // Bus clock
  input  wire logic        sel_i,     // Select one pin level
  input  wire logic        sel_pol_i, // Select active level
  input  wire logic        ack_pol_i, // Acknowledge active level
  input  wire logic        ack_en_i,  // Answer at all
  output logic             ack_o,     // Acknowledge to the port
  output logic      [15:0] data_o     // Read data to the port
);
  logic [1:0] wait_cnt = 2'h0; // Slow answer delay
  initial ack_o = 1'b0;
  initial data_o = 16'h0000;
  // Answer two cycles into a selected access, idle level otherwise
  always @(posedge clk_i) begin
    if (sel_i == sel_pol_i) begin
      wait_cnt <= wait_cnt + 2'h1;
      data_o   <= 16'hA55A;
    end else begin
      wait_cnt <= 2'h0;
      data_o   <= ~data_o; // Released bus keeps no stale value
    end
    ack_o <= (ack_en_i && wait_cnt == 2'h2) ? ack_pol_i : ~ack_pol_i;
  end
endmodule : ext_mem_model

// ==== verification/parallel_master_bus_config_test.sv ====
`timescale 1ns/100ps
module parallel_master_bus_config_test;
  logic clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;     // Register index
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, v, r;
  logic cpu_valid_i = 1'b0, alt_valid_i = 1'b0, ack, ready, done, b;
  pmp_cfg_pkg::req_t cpu_req_i = '0, alt_req_i = '0; // Request bodies
  logic [22:0] a_o, a_oe;             // Address pins
  logic [1:0]  s_o, s_oe;             // Select pins
  logic [3:0]  st_oe;                 // Strobe and lane enables
  logic [15:0] mem_d, rd_o, q;        // Memory data, result, read temp
  logic        s_pol = 1'b0, a_pol = 1'b0, a_en = 1'b1; // Model setup
  int num_errors = 0, samples_checked = 0, dones = 0, i;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (done === 1'b1) dones++; // Count end pulses
  parallel_master_bus_config dut (.clk_i, .rstn_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cpu_valid_i,
    .cpu_req_i, .alt_valid_i, .alt_req_i, .req_ready_o(ready),
    .done_o(done), .rdata_o(rd_o), .ack_input_i(ack), .addr_pins_o(a_o),
    .addr_pins_oe_o(a_oe), .data_pins_o(), .data_pins_oe_o(),
    .data_pins_i(mem_d), .select_pin_o(s_o), .select_pin_oe_o(s_oe),
    .write_strobe_pin_o(), .write_strobe_pin_oe_o(st_oe[3]),
    .read_strobe_pin_o(), .read_strobe_pin_oe_o(st_oe[2]),
    .high_lane_enable_pin_o(), .high_lane_enable_pin_oe_o(st_oe[1]),
    .low_lane_enable_pin_o(), .low_lane_enable_pin_oe_o(st_oe[0]));
  ext_mem_model mem (.clk_i, .sel_i(s_o[0]), .sel_pol_i(s_pol),
    .ack_pol_i(a_pol), .ack_en_i(a_en), .ack_o(ack), .data_o(mem_d));
  // Compare and count
  task automatic chk(input string n, input logic [23:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(negedge clk_i); // Let the write settle before any check
  endtask : wr
  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    d = reg_rdata_o; // Still standing, no read since
  endtask : rd
  // CPU read transaction; busy sampled early, end awaited with a bound
  task automatic xfer(input logic [23:0] a, input int lim, output logic bz);
    int d0, n;
    d0 = dones;
    @(posedge clk_i);
    cpu_valid_i <= 1'b1;
    cpu_req_i <= '{addr: a, wdata: 16'h3C3C, write: 1'b0};
    @(posedge clk_i);
    cpu_valid_i <= 1'b0;
    rd(pmp_cfg_pkg::IDX_CTL2, r);
    bz = r[15];
    chk("ready", !bz, ready);
    for (n = 0; n < lim && dones == d0; n++) @(posedge clk_i);
    if (dones == d0) begin
      chk("done_o", 24'h1, 24'h0);
      conclude();
    end
  endtask : xfer
  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    #(25 * 90000);
    num_errors++;
    conclude();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h4a79));
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(4'h5, v); chk("cs1bs", 24'h0200, v);
    rd(4'h7, v); chk("cs2bs", 24'h0600, v);
    rd(4'h1, v); chk("ctl2", 24'h0400, v);
    for (i = 0; i < 6; i++) begin
      v = 16'($urandom);
      r = 16'($urandom);
      wr(4'h2, v); wr(4'h3, r); wr(4'h6, v); wr(4'h5, r);
      chk("addr_oe", {v[6:0], r}, a_oe);
      chk("strobe_oe", v[15:12], st_oe);
      rd(4'h2, q); chk("ctl3", v & 16'hF77F, q);
      rd(4'h6, q); chk("cs2cf", v & 16'hF7E0, q);
      rd(4'h5, q); chk("cs1bs_w", r & 16'hFF88, q);
    end
    wr(4'hA, 16'hFFFF); rd(4'hA, v); chk("unmapped", 24'h0, v);
    wr(4'h4, 16'h6000); chk("sel_idle_hi", 24'h2, {s_oe[0], s_o[0]});
    wr(4'h4, 16'hA000); chk("sel_off", 24'h0, s_oe[0]);
    wr(4'h4, 16'h2000); chk("sel_idle_lo", 24'h3, {s_oe[0], s_o[0]});
    wr(4'h5, 16'h0200); wr(4'h7, 16'h0600); wr(4'h0, 16'h0000);
    xfer(24'h030000, 40, b); chk("busy_idle", 24'h0, b);
    rd(4'h1, v); chk("err_set", 24'h1, v[13]);
    wr(4'h1, 16'h0000); rd(4'h1, v); chk("err_clr", 24'h0400, v);
    wr(4'h0, 16'h0003);
    xfer(24'h030000, 40, b); chk("busy", 24'h1, b);
    chk("rdata", 24'h5A, rd_o);
    rd(4'h1, v); chk("err_ok", 24'h0400, v);
    wr(4'h4, 16'h2060); xfer(24'h030000, 40, b);
    rd(4'h1, v); chk("err_width", 24'h1, v[13]);
    wr(4'h1, 16'h0000);
    wr(4'h4, 16'h2080); wr(4'h0, 16'h0013); a_pol = 1'b1; a_en = 1'b0;
    xfer(24'h030000, 1200, b); rd(4'h1, v); chk("tout", 24'h1, v[12]);
    wr(4'h1, 16'h0000); a_en = 1'b1;
    xfer(24'h030000, 40, b); rd(4'h1, v); chk("ack", 24'h0400, v);
    wr(4'h7, 16'h0000); wr(4'h0, 16'h0003); xfer(24'h700000, 40, b);
    rd(4'h1, v); chk("cs1_top", 24'h0400, v);
    chk("cs1_data", 24'h5A, rd_o);
    wr(4'h2, 16'h0100); wr(4'h0, 16'h0007); xfer(24'h700000, 40, b);
    chk("latch_busy", 24'h1, b); chk("latch_data", 24'h5A, rd_o);
    wr(4'h0, 16'h0003);
    wr(4'h1, 16'h0100); rd(4'h1, v); chk("cur_alt", 24'h0, v[10]);
    alt_req_i <= '{addr: 24'($urandom), wdata: 16'h0000, write: 1'b1};
    alt_valid_i <= 1'b1;
    rd(4'h1, v); chk("alt_req", 24'h1, v[11]);
    wr(4'h1, 16'h0300); repeat (2) @(posedge clk_i);
    chk("bypass", alt_req_i.addr[22:0], a_o);
    alt_valid_i <= 1'b0;
    conclude();
  end
endmodule : parallel_master_bus_config_test
